// File: hdl/pmtr_pkg.sv
// constants and types shared by the program memory table read block
package pmtr_pkg;
	// ********************************************************
	// instruction cycle timing
	// ********************************************************
	localparam int unsigned PHASES = 4;
	localparam int unsigned TR_CYCLES = 2;
	localparam logic [1:0] PH_T1 = 2'h0;
	localparam logic [1:0] PH_T2 = 2'h1;
	localparam logic [1:0] PH_T4 = 2'h3;
	localparam logic [2:0] TR_FIRST = 3'h0;
	localparam logic [2:0] TR_RD = 3'h5;
	localparam logic [2:0] TR_CAP = 3'h6;
	localparam logic [2:0] TR_LAST = 3'((PHASES * TR_CYCLES) - 1);
	// ********************************************************
	// memory layout
	// ********************************************************
	localparam int unsigned BYTE_W = 8;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam int unsigned DEST_W = 11;
	localparam int unsigned SECT_LSB = 8;
	localparam logic [2:0] SECTOR0 = 3'h0;
	// ********************************************************
	// serial programming frame: command bit, 13 address bits, 16 data bits
	// ********************************************************
	localparam logic [5:0] ICP_HDR_BITS = 6'h0E;
	localparam logic [5:0] ICP_FRAME_BITS = 6'h1E;
	localparam logic [5:0] ICP_WORD_BITS = 6'h10;
	localparam logic ICP_CMD_WR = 1'b1;
	typedef enum logic [1:0] {
		TABLE_READ_OP,
		TABLE_READ_LAST_PAGE_OP,
		EXT_TABLE_READ_OP,
		EXT_TABLE_READ_LAST_PAGE_OP
	} pmtr_op_e;
	typedef enum logic [1:0] {
		ICP_HDR,
		ICP_WDATA,
		ICP_RDATA
	} pmtr_icp_e;
endpackage

// File: hdl/pmtr_mem_if.sv
// program memory port between the table read logic and the array
`timescale 1ns/1ns
`default_nettype none
interface pmtr_mem_if #(
	parameter int ADDR_W = 13,
	parameter int WORD_W = 16
);
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [WORD_W-1:0] rd_data;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [WORD_W-1:0] wr_data;
	modport requester (output rd_en, output rd_addr, input rd_data,
		output wr_en, output wr_addr, output wr_data);
	modport memory (input rd_en, input rd_addr, output rd_data,
		input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// File: hdl/pmtr_prog_mem.sv
// program memory array, one read and one write port
`timescale 1ns/1ns
`default_nettype none
module pmtr_prog_mem #(
	parameter int ADDR_W = 13,
	parameter int WORD_W = 16,
	parameter int DEPTH = 8192
) (
	input wire logic clk_in,
	pmtr_mem_if.memory mem
);
	// ********************************************************
	// storage
	// ********************************************************
	// addresses past DEPTH alias back into the array
	logic [WORD_W-1:0] words [DEPTH];
	logic [WORD_W-1:0] rd_q;

	always_ff @(posedge clk_in) begin
		if (mem.wr_en) begin
			words[32'(mem.wr_addr) % DEPTH] <= mem.wr_data;
		end
		if (mem.rd_en) begin
			rd_q <= words[32'(mem.rd_addr) % DEPTH];
		end
	end

	assign mem.rd_data = rd_q;
endmodule
`default_nettype wire

// File: hdl/pmtr_table_read.sv
// program memory fetch, table read and serial programming port
// Functional notes
// - program memory is an array of 16-bit words addressed by fetch counter.
// - first fetch after any reset comes from address 000H.
// - table address is high pointer bits above low pointer byte; last page forms put all ones in place of the high pointer.
// - low byte of the read word goes to the destination data location.
// - high byte of the read word loads the table high latch.
// - high byte bits with no memory bit behind them load as zero.
// - standard forms only target sector 0; other sectors need extended forms.
// - low pointer is an offset into the page chosen by high pointer, or into the last page for last page forms.
// - every table read variant takes exactly two instruction cycles.
// - software may both write and read the table high latch.
// - programming moves words serially both ways on one data line plus clock.
// - an instruction cycle is four phases of the system clock.
`timescale 1ns/1ns
`default_nettype none
module pmtr_table_read #(
	parameter int ADDR_W = 13,
	parameter int WORD_W = 16,
	parameter int DEPTH = 8192
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] next_pc_in,
	output logic [ADDR_W-1:0] fetch_addr_out,
	output logic [WORD_W-1:0] instr_word_out,
	output logic [1:0] phase_out,
	input wire logic req_in,
	input wire pmtr_pkg::pmtr_op_e op_in,
	input wire logic [pmtr_pkg::DEST_W-1:0] dest_addr_in,
	input wire logic [7:0] tbl_ptr_low_in,
	input wire logic [7:0] tbl_ptr_high_in,
	output logic busy_out,
	output logic done_out,
	output logic refused_out,
	output logic dmem_wr_out,
	output logic [pmtr_pkg::DEST_W-1:0] dmem_addr_out,
	output logic [7:0] dmem_data_out,
	input wire logic tbl_high_wr_in,
	input wire logic [7:0] tbl_high_wdata_in,
	output logic [7:0] table_high_latch_out,
	input wire logic prog_mode_in,
	input wire logic prog_serial_clock_in,
	input wire logic prog_serial_data_in,
	output logic prog_serial_data_out,
	output logic prog_serial_data_oe_n_out
);
	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [1:0] phase;
		logic busy;
		logic [2:0] cnt;
		logic refuse;
		pmtr_pkg::pmtr_op_e op;
		logic [ADDR_W-1:0] tr_addr;
		logic [pmtr_pkg::DEST_W-1:0] dest;
		logic [ADDR_W-1:0] fetch_addr;
		logic [WORD_W-1:0] instr;
		logic done;
		logic refused;
		logic dmem_wr;
		logic [7:0] dmem_data;
		logic [7:0] hi_latch;
		logic [2:0] mode_s;
		logic [2:0] sclk_s;
		logic [1:0] sdat_s;
		pmtr_pkg::pmtr_icp_e icp;
		logic [5:0] bits;
		logic [ADDR_W:0] hdr;
		logic [WORD_W-1:0] shift;
		logic icp_rd;
		logic icp_load;
		logic icp_wr;
		logic sd_out;
		logic sd_oe_n;
	} pmtr_state_s;

	pmtr_state_s s_q;
	pmtr_state_s s_d;
	pmtr_mem_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) mem_bus ();

	pmtr_prog_mem #(.ADDR_W(ADDR_W), .WORD_W(WORD_W), .DEPTH(DEPTH)) u_mem (
		.clk_in(clk_in),
		.mem(mem_bus.memory)
	);

	logic start;
	logic is_last;
	logic is_std;
	logic [15:0] full_ptr;
	logic [ADDR_W-1:0] tr_addr;
	logic [7:0] hi_byte;
	logic prog_on;
	logic sclk_rise;
	logic sclk_fall;

	// ********************************************************
	// address forming and decode
	// ********************************************************
	always_comb begin
		start = req_in && !s_q.busy && s_q.phase == pmtr_pkg::PH_T1 && !prog_on;
		is_last = op_in == pmtr_pkg::TABLE_READ_LAST_PAGE_OP ||
			op_in == pmtr_pkg::EXT_TABLE_READ_LAST_PAGE_OP;
		is_std = op_in == pmtr_pkg::TABLE_READ_OP || op_in == pmtr_pkg::TABLE_READ_LAST_PAGE_OP;
		full_ptr = {tbl_ptr_high_in, tbl_ptr_low_in};
		if (is_last) begin
			full_ptr[15:8] = 8'hFF;
		end
		// dropping the top pointer bits wraps within the array
		tr_addr = full_ptr[ADDR_W-1:0];
		// missing upper word bits read back as zero
		hi_byte = '0;
		hi_byte[WORD_W-pmtr_pkg::BYTE_W-1:0] = mem_bus.rd_data[WORD_W-1:pmtr_pkg::BYTE_W];
		prog_on = s_q.mode_s[1];
		sclk_rise = s_q.sclk_s[1] && !s_q.sclk_s[2];
		sclk_fall = !s_q.sclk_s[1] && s_q.sclk_s[2];
	end

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		s_d = s_q;
		s_d.phase = s_q.phase + 2'h1;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;
		s_d.dmem_wr = 1'b0;
		s_d.icp_rd = 1'b0;
		s_d.icp_load = s_q.icp_rd;
		s_d.icp_wr = 1'b0;
		s_d.mode_s = {s_q.mode_s[1:0], prog_mode_in};
		s_d.sclk_s = {s_q.sclk_s[1:0], prog_serial_clock_in};
		s_d.sdat_s = {s_q.sdat_s[0], prog_serial_data_in};
		if (s_q.phase == pmtr_pkg::PH_T2 && !prog_on) begin
			s_d.instr = mem_bus.rd_data;
		end
		if (s_q.phase == pmtr_pkg::PH_T4 && !prog_on) begin
			s_d.fetch_addr = next_pc_in;
		end
		// software write to the latch loses to a finishing table read that is not refused
		if (tbl_high_wr_in) begin
			s_d.hi_latch = tbl_high_wdata_in;
		end
		if (start) begin
			s_d.busy = 1'b1;
			s_d.cnt = pmtr_pkg::TR_FIRST + 3'h1;
			s_d.op = op_in;
			s_d.tr_addr = tr_addr;
			s_d.dest = dest_addr_in;
			// standard forms reach sector 0 only
			s_d.refuse = is_std &&
				dest_addr_in[pmtr_pkg::DEST_W-1:pmtr_pkg::SECT_LSB] != pmtr_pkg::SECTOR0;
		end else if (s_q.busy) begin
			s_d.cnt = s_q.cnt + 3'h1;
			if (s_q.cnt == pmtr_pkg::TR_CAP) begin
				s_d.done = 1'b1;
				s_d.refused = s_q.refuse;
				s_d.dmem_wr = !s_q.refuse;
				s_d.dmem_data = mem_bus.rd_data[7:0];
				if (!s_q.refuse) begin
					s_d.hi_latch = hi_byte;
				end
			end
			if (s_q.cnt == pmtr_pkg::TR_LAST) begin
				s_d.busy = 1'b0;
			end
		end
		// serial programming frames restart whenever the mode drops
		if (!prog_on) begin
			s_d.icp = pmtr_pkg::ICP_HDR;
			s_d.bits = '0;
			s_d.sd_oe_n = 1'b1;
			s_d.sd_out = 1'b0;
		end else begin
			case (s_q.icp)
				pmtr_pkg::ICP_HDR: begin
					if (sclk_rise) begin
						s_d.hdr = {s_q.hdr[ADDR_W-1:0], s_q.sdat_s[1]};
						s_d.bits = s_q.bits + 6'h01;
						if (s_q.bits + 6'h01 == pmtr_pkg::ICP_HDR_BITS) begin
							if (s_q.hdr[ADDR_W-1] == pmtr_pkg::ICP_CMD_WR) begin
								s_d.icp = pmtr_pkg::ICP_WDATA;
							end else begin
								s_d.icp = pmtr_pkg::ICP_RDATA;
								s_d.icp_rd = 1'b1;
								s_d.bits = '0;
							end
						end
					end
				end
				pmtr_pkg::ICP_WDATA: begin
					if (sclk_rise) begin
						s_d.shift = {s_q.shift[WORD_W-2:0], s_q.sdat_s[1]};
						s_d.bits = s_q.bits + 6'h01;
						if (s_q.bits + 6'h01 == pmtr_pkg::ICP_FRAME_BITS) begin
							s_d.icp_wr = 1'b1;
							s_d.icp = pmtr_pkg::ICP_HDR;
							s_d.bits = '0;
						end
					end
				end
				pmtr_pkg::ICP_RDATA: begin
					// word goes out msb first, changing on falling clock edges
					if (s_q.icp_load) begin
						s_d.shift = mem_bus.rd_data;
					end else if (sclk_fall) begin
						s_d.sd_oe_n = 1'b0;
						s_d.sd_out = s_q.shift[WORD_W-1];
						s_d.shift = {s_q.shift[WORD_W-2:0], 1'b0};
						s_d.bits = s_q.bits + 6'h01;
						if (s_q.bits == pmtr_pkg::ICP_WORD_BITS) begin
							s_d.sd_oe_n = 1'b1;
							s_d.icp = pmtr_pkg::ICP_HDR;
							s_d.bits = '0;
						end
					end
				end
				default: begin
					s_d.icp = pmtr_pkg::ICP_HDR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
			s_q.fetch_addr <= pmtr_pkg::RESET_VECTOR[ADDR_W-1:0];
			s_q.sd_oe_n <= 1'b1;
			s_q.op <= pmtr_pkg::TABLE_READ_OP;
			s_q.icp <= pmtr_pkg::ICP_HDR;
		end else begin
			s_q <= s_d;
		end
	end

	// ********************************************************
	// memory port: programming first, then table read, then fetch
	// ********************************************************
	always_comb begin
		mem_bus.rd_en = 1'b0;
		mem_bus.rd_addr = s_q.fetch_addr;
		if (prog_on) begin
			mem_bus.rd_en = s_q.icp_rd;
			mem_bus.rd_addr = s_q.hdr[ADDR_W-1:0];
		end else if (s_q.busy && s_q.cnt == pmtr_pkg::TR_RD) begin
			mem_bus.rd_en = 1'b1;
			mem_bus.rd_addr = s_q.tr_addr;
		end else if (s_q.phase == pmtr_pkg::PH_T1) begin
			mem_bus.rd_en = 1'b1;
		end
		mem_bus.wr_en = s_q.icp_wr;
		mem_bus.wr_addr = s_q.hdr[ADDR_W-1:0];
		mem_bus.wr_data = s_q.shift;
	end

	assign fetch_addr_out = s_q.fetch_addr;
	assign instr_word_out = s_q.instr;
	assign phase_out = s_q.phase;
	assign busy_out = s_q.busy;
	assign done_out = s_q.done;
	assign refused_out = s_q.refused;
	assign dmem_wr_out = s_q.dmem_wr;
	assign dmem_addr_out = s_q.dest;
	assign dmem_data_out = s_q.dmem_data;
	assign table_high_latch_out = s_q.hi_latch;
	assign prog_serial_data_out = s_q.sd_out;
	assign prog_serial_data_oe_n_out = s_q.sd_oe_n;

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence tr_taken;
		start;
	endsequence
	sequence tr_ends;
		##7 done_out ##1 !busy_out;
	endsequence

	AST_PHASE_WRAP: assert property (s_q.phase == pmtr_pkg::PH_T4 |=> phase_out == pmtr_pkg::PH_T1)
		else $error("phase did not wrap after T4");
	AST_TWO_CYCLES: assert property (tr_taken |-> tr_ends)
		else $error("table read not two instruction cycles");
	AST_RESET_VECTOR: assert property (!$past(rst_n_in) |-> fetch_addr_out == '0)
		else $error("first fetch not at reset vector");
	AST_ADDR_FORM: assert property (start && !is_last |-> ##5 (mem_bus.rd_addr ==
		ADDR_W'({$past(tbl_ptr_high_in, 5), $past(tbl_ptr_low_in, 5)})))
		else $error("table address not formed from pointers");
	AST_LAST_PAGE: assert property (start && is_last |-> ##5
		(mem_bus.rd_addr[ADDR_W-1:8] == '1))
		else $error("last page read outside last page");
	AST_LOW_BYTE: assert property (dmem_wr_out |-> dmem_data_out == $past(mem_bus.rd_data[7:0]))
		else $error("low byte not written to data memory");
	AST_HIGH_BYTE: assert property (dmem_wr_out |-> table_high_latch_out == $past(hi_byte))
		else $error("high byte not loaded into latch");
	AST_SECTOR_REFUSE: assert property (start && is_std &&
		dest_addr_in[pmtr_pkg::DEST_W-1:pmtr_pkg::SECT_LSB] != pmtr_pkg::SECTOR0
		|-> ##7 (refused_out && !dmem_wr_out))
		else $error("standard form wrote outside sector 0");
	AST_LATCH_WRITE: assert property (tbl_high_wr_in &&
		!(s_q.busy && s_q.cnt == pmtr_pkg::TR_CAP)
		|=> table_high_latch_out == $past(tbl_high_wdata_in))
		else $error("latch write from software lost");
	AST_PROG_RELEASE: assert property (!prog_on |=> prog_serial_data_oe_n_out)
		else $error("data line driven outside programming");
endmodule
`default_nettype wire

// File: verif/pmtr_prog_model.sv
// serial programmer model that drives the programming clock and data lines
`timescale 1ns/1ns
`default_nettype none
module pmtr_prog_model (
	input wire logic clk_in,
	input wire logic data_wire_in,
	output logic mode_out,
	output logic ser_clk_out,
	output logic ser_data_out
);
	// each level lasts 6 system clocks: the device sees the pins through a 2-stage sync
	localparam int HOLD = 6;
	initial begin
		mode_out = 1'b0;
		ser_clk_out = 1'b0;
		ser_data_out = 1'b0;
	end
	task automatic half();
		repeat (HOLD) @(negedge clk_in);
	endtask
	// clock stands low between bits and frames, data set while it is low
	task automatic send_bit(input logic b);
		ser_data_out = b;
		half();
		ser_clk_out = 1'b1;
		half();
		ser_clk_out = 1'b0;
	endtask
	// during a write frame only this model drives the clock and data lines; a read hands the data line to the device
	task automatic write_word(input logic [12:0] a, input logic [15:0] w);
		logic [29:0] f;
		f = {pmtr_pkg::ICP_CMD_WR, a, w};
		mode_out = 1'b1;
		half();
		for (int i = 29; i >= 0; i--) begin
			send_bit(f[i]);
		end
		half();
		mode_out = 1'b0;
		half();
	endtask
	task automatic read_word(input logic [12:0] a, output logic [15:0] w);
		logic [13:0] f;
		f = {~pmtr_pkg::ICP_CMD_WR, a};
		mode_out = 1'b1;
		half();
		for (int i = 13; i >= 0; i--) begin
			send_bit(f[i]);
		end
		// released: the line must not keep showing our last bit
		ser_data_out = ~ser_data_out;
		for (int i = 15; i >= 0; i--) begin
			half();
			w[i] = data_wire_in;
			ser_clk_out = 1'b1;
			half();
			ser_clk_out = 1'b0;
		end
		half();
		mode_out = 1'b0;
		half();
	endtask
endmodule
`default_nettype wire

// File: verif/pmtr_table_read_test.sv
// self-checking bench for the program memory table read block
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(a, e) check_val(64'(a), 64'(e))
module pmtr_table_read_test;
	// ********************************************************
	// stimulus, outputs and bookkeeping
	// ********************************************************
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [12:0] next_pc_in = 13'h0000;
	logic req_in = 1'b0;
	pmtr_pkg::pmtr_op_e op_in = pmtr_pkg::TABLE_READ_OP;
	logic [10:0] dest_in = 11'h000;
	logic [7:0] ptr_lo = 8'h00;
	logic [7:0] ptr_hi = 8'h00;
	logic hi_wr = 1'b0;
	logic [7:0] hi_wdata = 8'h00;
	logic [12:0] fetch_addr;
	logic [15:0] instr_word;
	logic [1:0] phase;
	logic busy, done, refused, dmem_wr, dout, oe_n, mode, sclk, md, ser_wire;
	logic [10:0] dmem_addr;
	logic [7:0] dmem_data, latch;
	int errors = 0;
	int checks_done = 0;
	integer seed = 32'hD8B49FA7;
	logic [28:0] exp_q [$];
	logic [15:0] mem [logic [12:0]];
	logic [7:0] latch_m = 8'h00;
	// data line: the device wins only while its enable is low
	assign ser_wire = (oe_n === 1'b0) ? dout : md;
	always #10 clk_in = ~clk_in;
	pmtr_table_read DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .next_pc_in(next_pc_in),
		.fetch_addr_out(fetch_addr), .instr_word_out(instr_word), .phase_out(phase),
		.req_in(req_in), .op_in(op_in), .dest_addr_in(dest_in), .tbl_ptr_low_in(ptr_lo),
		.tbl_ptr_high_in(ptr_hi), .busy_out(busy), .done_out(done), .refused_out(refused),
		.dmem_wr_out(dmem_wr), .dmem_addr_out(dmem_addr), .dmem_data_out(dmem_data),
		.tbl_high_wr_in(hi_wr), .tbl_high_wdata_in(hi_wdata), .table_high_latch_out(latch),
		.prog_mode_in(mode), .prog_serial_clock_in(sclk), .prog_serial_data_in(ser_wire),
		.prog_serial_data_out(dout), .prog_serial_data_oe_n_out(oe_n));
	pmtr_prog_model PROG (.clk_in(clk_in), .data_wire_in(ser_wire), .mode_out(mode),
		.ser_clk_out(sclk), .ser_data_out(md));
	// ********************************************************
	// tasks
	// ********************************************************
	task automatic check_val(input logic [63:0] a, input logic [63:0] e);
		checks_done++;
		if (a !== e) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic close_out();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic table_read(input pmtr_pkg::pmtr_op_e op, input logic [10:0] dest,
		input logic [7:0] hi, input logic [12:0] a);
		logic refuse;
		refuse = (op < pmtr_pkg::EXT_TABLE_READ_OP) && (dest[10:8] != pmtr_pkg::SECTOR0);
		@(negedge clk_in);
		while (phase !== 2'h0 || busy !== 1'b0) begin
			@(negedge clk_in);
		end
		op_in = op;
		dest_in = dest;
		ptr_hi = hi;
		ptr_lo = a[7:0];
		req_in = 1'b1;
		if (refuse) begin
			exp_q.push_back({2'b10, 19'h00000, latch_m});
		end else begin
			latch_m = mem[a][15:8];
			exp_q.push_back({2'b01, dest, mem[a][7:0], latch_m});
		end
		@(negedge clk_in);
		req_in = 1'b0;
		// pointers are only sampled at the taking edge
		ptr_lo = 8'($random(seed));
		// done rises on the edge six clocks after the taking edge
		repeat (5) @(negedge clk_in);
		`CHECK_EQ({busy, done}, 2'b10);
		@(negedge clk_in);
		`CHECK_EQ(done, 1'b1);
	endtask
	// ********************************************************
	// result watcher and watchdog
	// ********************************************************
	always @(negedge clk_in) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHECK_EQ(done, 1'b0);
			end else begin
				`CHECK_EQ({refused, dmem_wr, refused ? 19'h00000 : {dmem_addr, dmem_data}, latch}, exp_q.pop_front());
			end
		end
	end
	initial begin
		repeat (6000) @(posedge clk_in);
		errors++;
		close_out();
	end
	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		logic [15:0] w;
		logic [12:0] a [5];
		repeat (4) @(negedge clk_in);
		`CHECK_EQ(fetch_addr, pmtr_pkg::RESET_VECTOR[12:0]);
		rst_n_in = 1'b1;
		a[0] = {5'h05, 8'($random(seed))};
		a[1] = {5'h1F, 8'($random(seed))};
		a[2] = {5'h05, 8'($random(seed))};
		a[3] = {5'h1F, 8'($random(seed))};
		a[4] = {5'h0A, 8'($random(seed))};
		for (int i = 0; i < 5; i++) begin
			mem[a[i]] = 16'($random(seed));
			PROG.write_word(a[i], mem[a[i]]);
		end
		PROG.read_word(a[2], w);
		`CHECK_EQ(w, mem[a[2]]);
		`CHECK_EQ(oe_n, 1'b1);
		next_pc_in = a[0];
		repeat (12) @(negedge clk_in);
		`CHECK_EQ({fetch_addr, instr_word}, {a[0], mem[a[0]]});
		table_read(pmtr_pkg::TABLE_READ_OP, {3'h0, 8'($random(seed))}, 8'h05, a[0]);
		table_read(pmtr_pkg::TABLE_READ_LAST_PAGE_OP, {3'h0, 8'h12}, 8'h05, a[1]);
		// top pointer bits beyond the memory size must not matter
		table_read(pmtr_pkg::EXT_TABLE_READ_OP, {3'h3, 8'h34}, 8'hE5, a[2]);
		table_read(pmtr_pkg::EXT_TABLE_READ_LAST_PAGE_OP, {3'h5, 8'h56}, 8'h00, a[3]);
		hi_wdata = 8'($random(seed));
		hi_wr = 1'b1;
		@(negedge clk_in);
		hi_wr = 1'b0;
		latch_m = hi_wdata;
		`CHECK_EQ(latch, latch_m);
		// standard form into a non-zero sector is refused and keeps the latch
		table_read(pmtr_pkg::TABLE_READ_OP, {3'h2, 8'h78}, 8'h0A, a[4]);
		rst_n_in = 1'b0;
		repeat (2) @(negedge clk_in);
		`CHECK_EQ({fetch_addr, latch}, 21'h000000);
		rst_n_in = 1'b1;
		repeat (4) @(negedge clk_in);
		close_out();
	end
endmodule
`default_nettype wire
